//--- core/qbs_sram_port.sv
// synchronous burst memory with separate read and write ports
// assumes the controller drives pins timed to linkClk (positive input
// clock); its falling edge stands for the negative input clock rise
`timescale 1ns/1ps

`include "qbs_defs.svh"

module qbs_sram_port
	import qbs_pkg::*;
#(
	parameter int ADDR_W      = `QBS_ADDR_W,
	parameter int LOCK_CYCLES = `QBS_LOCK_CYC,
	parameter int ZQ_CYCLES   = `QBS_ZQ_CYC
) (
	input  wire logic                   clock,          // core clock
	input  wire logic                   rstn,           // async reset
	input  wire logic                   linkClk,        // input clock
	input  wire logic                   outClkPos,      // output clock
	input  wire logic                   outClkNeg,      // output clock
	input  wire logic                   dll_disable_n,  // static pin
	input  wire logic                   read_port_select_n,
	input  wire logic                   write_port_select_n,
	input  wire logic [ADDR_W-1:0]      addr,           // shared address
	input  wire qbs_beat_t              wrBeat,         // data + selects
	output logic [`QBS_WORD_W-1:0]      rdData,         // read data
	output logic                        rdDataOeN,      // low: driving
	output logic                        echo_strobe_pos,
	output logic                        echo_strobe_neg,
	output logic                        dllLocked,      // core domain
	output logic                        driveUpdate     // retune pulse
);

	// refuse sizes the counters and memory cannot serve
	generate
		if (ADDR_W < 1 || ADDR_W > `QBS_ADDR_W_MAX) begin : g_bad_addr
			$error("ADDR_W out of range");
		end
		if (LOCK_CYCLES < 2 || LOCK_CYCLES > `QBS_LOCK_CYC) begin : g_bad_lk
			$error("LOCK_CYCLES out of range");
		end
		if (ZQ_CYCLES < 2 || ZQ_CYCLES > `QBS_ZQ_CYC) begin : g_bad_zq
			$error("ZQ_CYCLES out of range");
		end
	endgenerate

	// merge one beat into a stored word, lane by lane
	function automatic logic [`QBS_WORD_W-1:0] mergeWord(
		input logic [`QBS_WORD_W-1:0] base,
		input qbs_beat_t              beat
	);
		logic [`QBS_WORD_W-1:0] w;
		w = base;
		if (!beat.bwN[0]) begin
			w[`QBS_LANE0_HI:0] = beat.data[`QBS_LANE0_HI:0];
		end
		if (!beat.bwN[1]) begin
			w[`QBS_WORD_W-1:`QBS_LANE1_LO] =
				beat.data[`QBS_WORD_W-1:`QBS_LANE1_LO];
		end
		return w;
	endfunction : mergeWord

	// ---------------- core clock domain ----------------
	logic [1:0]               rstPipe_q;   // reset release stages
	logic                     coreRstN;    // released reset copy
	logic [1:0]               lockSync_q;  // lock flag crossing
	logic [`QBS_ZQ_CNT_W-1:0] zqCnt_q;     // retune interval counter
	logic                     zqPulse_q;   // retune strobe
	logic                     lockDone_q;  // dll ready, link domain

	assign coreRstN  = rstPipe_q[1];
	assign dllLocked = lockSync_q[1];
	assign driveUpdate = zqPulse_q;

	// reset release through two stages
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end

	// lock level from the link domain, two stages
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			lockSync_q <= 2'h0;
		end else begin
			lockSync_q <= {lockSync_q[0], lockDone_q};
		end
	end

	// periodic driver strength retune
	always_ff @(posedge clock or negedge coreRstN) begin
		if (!coreRstN) begin
			zqCnt_q   <= '0;
			zqPulse_q <= 1'b0;
		end else if (zqCnt_q == `QBS_ZQ_CNT_W'(ZQ_CYCLES - 1)) begin
			zqCnt_q   <= '0;
			zqPulse_q <= 1'b1;
		end else begin
			zqCnt_q   <= zqCnt_q + 1'b1;
			zqPulse_q <= 1'b0;
		end
	end

	// ---------------- link clock domain ----------------
	logic [1:0]                 linkRst_q;   // link reset stages
	logic                       linkRstN;    // link reset copy
	logic [1:0]                 dllPin_q;    // dll pin sync
	logic [1:0]                 strapPin_q;  // output clock strap sync
	logic                       strapTaken_q; // strap caught once
	logic                       singleClk_q; // single clock mode
	logic [`QBS_LOCK_CNT_W-1:0] lockCnt_q;   // lock wait counter
	logic                       dllOn;       // 1.5 cycle latency
	qbs_op_t                    lastOp_q;    // access of last rise
	logic                       rdGo;        // read accepted now
	logic                       wrGo;        // write accepted now
	logic [2:0]                 rdPipe_q;    // read burst stages
	logic [2:0]                 wrPipe_q;    // write burst stages
	logic [ADDR_W-1:0]          rdAddrA_q;   // newest read address
	logic [ADDR_W-1:0]          rdAddrB_q;   // address being output
	logic [ADDR_W-1:0]          wrAddr_q;    // newest write address
	logic [ADDR_W-1:0]          tagPos_q;    // address of beats 0/2
	logic [ADDR_W-1:0]          tag1_q;      // address of beat 1
	logic [ADDR_W-1:0]          tag3_q;      // address of beat 3
	qbs_beat_t                  beat0_q;     // rising-edge beats
	qbs_beat_t                  beat2_q;
	qbs_beat_t                  beat1_q;     // falling-edge beats
	qbs_beat_t                  beat3_q;
	logic                       vld0_q;      // beat holds live data
	logic                       vld2_q;
	logic                       vld1_q;
	logic                       vld3_q;
	logic [`QBS_WORD_W-1:0]     qPos_q;      // rising-edge output word
	logic [`QBS_WORD_W-1:0]     qNeg_q;      // falling-edge output word
	logic                       oePosN_q;    // rising half enable
	logic                       oeNegN_q;    // falling half enable
	logic [`QBS_LINE_W-1:0]     mem [2**ADDR_W]; // burst lines

	assign linkRstN = linkRst_q[1];
	assign dllOn    = dllPin_q[1];

	// one word of a line with any newer uncommitted beat laid over it
	function automatic logic [`QBS_WORD_W-1:0] fetchWord(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        idx
	);
		logic [`QBS_LINE_W-1:0] line;
		logic [`QBS_WORD_W-1:0] w;
		line = mem[a];
		w    = line[int'(idx) * `QBS_WORD_W +: `QBS_WORD_W];
		unique case (idx)
			2'h0: if (vld0_q && tagPos_q == a) w = mergeWord(w, beat0_q);
			2'h1: if (vld1_q && tag1_q == a)   w = mergeWord(w, beat1_q);
			2'h2: if (vld2_q && tagPos_q == a) w = mergeWord(w, beat2_q);
			2'h3: if (vld3_q && tag3_q == a)   w = mergeWord(w, beat3_q);
		endcase
		return w;
	endfunction : fetchWord

	// link reset release and static pin synchronisers
	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			linkRst_q  <= 2'h0;
			dllPin_q   <= 2'h0;
			strapPin_q <= 2'h0;
		end else begin
			linkRst_q  <= {linkRst_q[0], 1'b1};
			dllPin_q   <= {dllPin_q[0], dll_disable_n};
			strapPin_q <= {strapPin_q[0], outClkPos & outClkNeg};
		end
	end

	// strap caught once after release, then fixed
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			strapTaken_q <= 1'b0;
			singleClk_q  <= 1'b0;
		end else if (!strapTaken_q) begin
			strapTaken_q <= 1'b1;
			singleClk_q  <= strapPin_q[1];
		end
	end

	// echo clocks free-run from output clocks or the input pair
	assign echo_strobe_pos = singleClk_q ? linkClk : outClkPos;
	assign echo_strobe_neg = singleClk_q ? ~linkClk : outClkNeg;

	// dll lock wait, bypassed when the dll is off
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			lockCnt_q  <= '0;
			lockDone_q <= 1'b0;
		end else if (!dllOn) begin
			lockCnt_q  <= '0;
			lockDone_q <= 1'b1;
		end else if (!lockDone_q) begin
			lockCnt_q  <= lockCnt_q + 1'b1;
			lockDone_q <= lockCnt_q == `QBS_LOCK_CNT_W'(LOCK_CYCLES - 1);
		end
	end

	// selects seen only on rising edges; repeats and clashes resolved
	assign rdGo = !read_port_select_n && lastOp_q != OP_READ;
	assign wrGo = !write_port_select_n && lastOp_q != OP_WRITE
		&& !rdGo;

	// access history for arbitration
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			lastOp_q <= OP_IDLE;
		end else begin
			unique case ({rdGo, wrGo})
				2'b10:   lastOp_q <= OP_READ;
				2'b01:   lastOp_q <= OP_WRITE;
				default: lastOp_q <= OP_IDLE;
			endcase
		end
	end

	// burst stage tracking and address capture
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			rdPipe_q  <= 3'h0;
			wrPipe_q  <= 3'h0;
			rdAddrA_q <= '0;
			rdAddrB_q <= '0;
			wrAddr_q  <= '0;
		end else begin
			rdPipe_q <= {rdPipe_q[1:0], rdGo};
			wrPipe_q <= {wrPipe_q[1:0], wrGo};
			if (rdGo) begin
				rdAddrA_q <= addr;
			end
			if (rdPipe_q[0]) begin
				rdAddrB_q <= rdAddrA_q;
			end
			if (wrGo) begin
				wrAddr_q <= addr;
			end
		end
	end

	// rising-edge write beats 0 and 2; other cycles ignore the pins
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			beat0_q  <= '0;
			beat2_q  <= '0;
			tagPos_q <= '0;
			vld0_q   <= 1'b0;
			vld2_q   <= 1'b0;
		end else if (wrPipe_q[0]) begin
			beat0_q  <= wrBeat;
			tagPos_q <= wrAddr_q;
			vld0_q   <= 1'b1;
			vld2_q   <= 1'b0;
		end else if (wrPipe_q[1]) begin
			beat2_q <= wrBeat;
			vld2_q  <= 1'b1;
		end
	end

	// falling-edge write beats 1 and 3
	always_ff @(negedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			beat1_q <= '0;
			beat3_q <= '0;
			tag1_q  <= '0;
			tag3_q  <= '0;
			vld1_q  <= 1'b0;
			vld3_q  <= 1'b0;
		end else if (wrPipe_q[1]) begin
			beat1_q <= wrBeat;
			tag1_q  <= tagPos_q;
			vld1_q  <= 1'b1;
		end else if (wrPipe_q[2]) begin
			beat3_q <= wrBeat;
			tag3_q  <= tagPos_q;
			vld3_q  <= 1'b1;
		end
	end

	// commit the four collected beats as one masked line
	always_ff @(posedge linkClk) begin
		if (linkRstN && wrPipe_q[2]) begin
			mem[tagPos_q] <= {
				mergeWord(mem[tagPos_q][3*`QBS_WORD_W +: `QBS_WORD_W], beat3_q),
				mergeWord(mem[tagPos_q][2*`QBS_WORD_W +: `QBS_WORD_W], beat2_q),
				mergeWord(mem[tagPos_q][`QBS_WORD_W +: `QBS_WORD_W], beat1_q),
				mergeWord(mem[tagPos_q][0 +: `QBS_WORD_W], beat0_q)
			};
		end
	end

	// rising-edge read word: odd words with dll, even words without
	always_ff @(posedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			qPos_q   <= '0;
			oePosN_q <= 1'b1;
		end else if (dllOn && rdPipe_q[1]) begin
			qPos_q   <= fetchWord(rdAddrB_q, 2'h1);
			oePosN_q <= 1'b0;
		end else if (dllOn && rdPipe_q[2]) begin
			qPos_q   <= fetchWord(rdAddrB_q, 2'h3);
			oePosN_q <= 1'b0;
		end else if (!dllOn && rdPipe_q[0]) begin
			qPos_q   <= fetchWord(rdAddrA_q, 2'h0);
			oePosN_q <= 1'b0;
		end else if (!dllOn && rdPipe_q[1]) begin
			qPos_q   <= fetchWord(rdAddrB_q, 2'h2);
			oePosN_q <= 1'b0;
		end else begin
			oePosN_q <= 1'b1;
		end
	end

	// falling-edge read word
	always_ff @(negedge linkClk or negedge linkRstN) begin
		if (!linkRstN) begin
			qNeg_q   <= '0;
			oeNegN_q <= 1'b1;
		end else if (rdPipe_q[1]) begin
			qNeg_q   <= fetchWord(rdAddrB_q, dllOn ? 2'h0 : 2'h1);
			oeNegN_q <= 1'b0;
		end else if (rdPipe_q[2]) begin
			qNeg_q   <= fetchWord(rdAddrB_q, dllOn ? 2'h2 : 2'h3);
			oeNegN_q <= 1'b0;
		end else begin
			oeNegN_q <= 1'b1;
		end
	end

	// double-rate output: each half shows the flop of its edge
	assign rdData    = linkClk ? qPos_q : qNeg_q;
	assign rdDataOeN = linkClk ? oePosN_q : oeNegN_q;

	// ---------------- checks ----------------
	sequence sReadStart;
		rdGo;
	endsequence

	sequence sWriteStart;
		wrGo;
	endsequence

	a_read_spacing: assert property (@(posedge linkClk)
		disable iff (!linkRstN) sReadStart |=> !rdGo)
		else $error("read accepted on consecutive rises");

	a_write_spacing: assert property (@(posedge linkClk)
		disable iff (!linkRstN) sWriteStart |=> !wrGo)
		else $error("write accepted on consecutive rises");

	a_single_start: assert property (@(posedge linkClk)
		disable iff (!linkRstN) !(rdGo && wrGo))
		else $error("two accesses started together");

	a_arb_read_first: assert property (@(posedge linkClk)
		disable iff (!linkRstN)
		(!read_port_select_n && !write_port_select_n
		&& lastOp_q == OP_IDLE)
		|-> rdGo ##1 (write_port_select_n || wrGo))
		else $error("dual select did not start read then write");

	a_write_commit: assert property (@(posedge linkClk)
		disable iff (!linkRstN) sWriteStart |-> ##3 wrPipe_q[2])
		else $error("write commit not three rises after start");

	a_read_latency_dll: assert property (@(posedge linkClk)
		disable iff (!linkRstN)
		(sReadStart and (dllOn && rdPipe_q[2:1] == 2'h0))
		|-> ##1 oePosN_q ##2 !oePosN_q)
		else $error("dll read word not on time");

	a_read_latency_nodll: assert property (@(posedge linkClk)
		disable iff (!linkRstN)
		(sReadStart and !dllOn) |-> ##2 !oePosN_q ##1 !oePosN_q)
		else $error("legacy read words not on time");

	a_read_release: assert property (@(posedge linkClk)
		disable iff (!linkRstN) rdPipe_q == 3'h0 |=> oePosN_q)
		else $error("read data driven with no burst pending");

	a_retune_period: assert property (@(posedge clock)
		disable iff (!coreRstN) driveUpdate |=> !driveUpdate [*8])
		else $error("retune pulses too close");

endmodule : qbs_sram_port

//--- core/qbs_defs.svh
// constants of the four-beat burst memory port: widths, lanes and counts
// assumes inclusion from the package and from the port module only
`ifndef QBS_DEFS_SVH
`define QBS_DEFS_SVH

`define QBS_WORD_W      18
`define QBS_BEATS       4
`define QBS_LINE_W      72
`define QBS_LANE0_HI    8
`define QBS_LANE1_LO    9
`define QBS_LOCK_CYC    1024
`define QBS_LOCK_CNT_W  11
`define QBS_ZQ_CYC      1024
`define QBS_ZQ_CNT_W    10
`define QBS_ADDR_W      18
`define QBS_ADDR_W_MAX  20

`endif

//--- core/qbs_pkg.sv
// types shared by the burst memory port and its test surroundings
// assumes qbs_defs.svh sits beside it in core/
package qbs_pkg;

`include "qbs_defs.svh"

	// one write beat: data word and its two active-low byte lane selects
	typedef struct packed {
		logic [`QBS_WORD_W-1:0] data;
		logic [1:0]             bwN;
	} qbs_beat_t;

	// access started on the previous positive input clock rise
	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10
	} qbs_op_t;

endpackage : qbs_pkg

//--- bench/qbs_ctrl_model.sv
// controller model: selects, address and write beats on linkClk
// assumes one issue() call per linkClk rise, made by the bench
`timescale 1ns/1ps
module qbs_ctrl_model
	import qbs_pkg::*;
(
	input  wire logic        linkClk,
	input  wire logic        dllOn,
	input  wire logic [17:0] rdData,
	input  wire logic        rdDataOeN,
	output logic             read_port_select_n,
	output logic             write_port_select_n,
	output logic [5:0]       addr,
	output qbs_beat_t        wrBeat
);
	// one captured burst with its enable flags
	typedef struct packed {
		logic [71:0] ln;
		logic        ok;
		logic        oa;
	} qbs_rd_t;
	qbs_rd_t rdQ[$];        // captured bursts, oldest first
	int      nIss = 0;      // count of issue calls
	int      lastWr = -9;   // issue index of last write with data

	// idle lines at time zero
	initial begin
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		addr = 6'h00;
		wrBeat = '0;
	end

	// one request set per rise; released address toggles
	task automatic issue(input logic r, w, d, input logic [5:0] a,
		input logic [71:0] ln, input logic [7:0] bw);
		int t;
		@(posedge linkClk);
		nIss++;
		t = nIss;
		read_port_select_n <= ~r;
		write_port_select_n <= ~w;
		addr <= (r | w) ? a : ~addr;
		if (w && d)
			lastWr = t;
		fork
			if (w && d) beats(t, ln, bw);
			if (r && !(w && d)) capture(); // a write with data wins
		join_none
	endtask : issue

	// four beats, each half a cycle ahead of its capture edge
	task automatic beats(input int t, input logic [71:0] ln,
		input logic [7:0] bw);
		@(posedge linkClk);                           // select is sampled here
		for (int k = 0; k < 4; k++) begin
			if (k % 2 == 0) @(negedge linkClk);
			else @(posedge linkClk);
			wrBeat <= {ln[18*k +: 18], bw[2*k +: 2]};
		end
		@(negedge linkClk);
		if (lastWr != t + 2)
			wrBeat <= ~wrBeat;                    // released lines invert
	endtask : beats

	// sample each word in the middle of its half period
	task automatic capture();
		qbs_rd_t c;
		c.ok = 1'b1;
		@(posedge linkClk);                           // select is sampled here
		@(posedge linkClk);                           // first rise after it
		if (dllOn)
			@(negedge linkClk);
		for (int k = 0; k < 4; k++) begin
			if (k > 0) @(linkClk);
			#20;
			c.ln[18*k +: 18] = rdData;
			c.ok = c.ok & (rdDataOeN === 1'b0);
		end
		@(linkClk);
		#20;
		c.oa = rdDataOeN;
		rdQ.push_back(c);
	endtask : capture

	// oldest burst, all zero when none arrives in time
	task automatic pop(output logic [71:0] ln, output logic ok, oa);
		int n = 0;
		while (rdQ.size() == 0 && n < 20) begin
			@(posedge linkClk);
			n++;
		end
		{ln, ok, oa} = (n < 20) ? rdQ.pop_front() : '0;
	endtask : pop
endmodule : qbs_ctrl_model

//--- bench/tb.sv
// bench for the burst memory port: clocks, resets, scenarios
// assumes qbs_ctrl_model stands on the controller side
`timescale 1ns/1ps
module tb;
	import qbs_pkg::*;
	logic        clock = 0;     // core clock, 40 ns
	logic        linkClk = 0;   // input clock, 80 ns
	logic        cDly = 0;      // output clock, skewed copy
	logic        rstn = 0;      // async reset
	logic        dllOn = 1;     // dll pin level
	logic        strapHi = 0;   // hold output clocks high
	logic        rSelN, wSelN, echoP, echoN, oeN, lock, upd;
	logic [5:0]  addr;
	qbs_beat_t   beat;
	logic [17:0] rdData;
	logic [71:0] mem [64];      // expected array content
	logic [71:0] expLn[$];      // expected bursts
	logic        expOa[$];      // expected enable after burst
	int          failures = 0;
	int          checked = 0;
	int          tick = 0;
	wire logic   outClkPos = strapHi ? 1'b1 : cDly;
	wire logic   outClkNeg = strapHi ? 1'b1 : ~cDly;

	// clocks, unrelated in phase
	always #20 clock = ~clock;
	initial begin
		#7;
		forever #40 linkClk = ~linkClk;
	end
	always @(linkClk) cDly <= #10 linkClk;

	qbs_sram_port #(.ADDR_W(6), .LOCK_CYCLES(8), .ZQ_CYCLES(16))
	i_qbs_sram_port (
		.clock(clock), .rstn(rstn), .linkClk(linkClk),
		.outClkPos(outClkPos), .outClkNeg(outClkNeg),
		.dll_disable_n(dllOn), .read_port_select_n(rSelN),
		.write_port_select_n(wSelN), .addr(addr), .wrBeat(beat),
		.rdData(rdData), .rdDataOeN(oeN), .echo_strobe_pos(echoP),
		.echo_strobe_neg(echoN), .dllLocked(lock), .driveUpdate(upd));

	qbs_ctrl_model i_qbs_ctrl_model (
		.linkClk(linkClk), .dllOn(dllOn), .rdData(rdData),
		.rdDataOeN(oeN), .read_port_select_n(rSelN),
		.write_port_select_n(wSelN), .addr(addr), .wrBeat(beat));

	// cut a hang short
	always @(posedge clock) begin
		tick <= tick + 1;
		if (tick == 8000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [71:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// lane merge: select k governs bits 9k+8..9k
	function automatic logic [71:0] merge(logic [71:0] o, n,
		logic [7:0] bw);
		for (int k = 0; k < 8; k++)
			if (!bw[k]) o[9*k +: 9] = n[9*k +: 9];
		return o;
	endfunction : merge

	task automatic doRst(input logic dll, strap);
		@(posedge clock);
		rstn <= 1'b0;
		dllOn <= dll;
		strapHi <= strap;
		repeat (20) @(posedge clock);
		chk("lock in reset", lock, 0);
		rstn <= 1'b1;
		repeat (4) @(posedge linkClk);
		chk("oeN idle", oeN, 1);
	endtask : doRst

	task automatic iss(input logic r, w, d, input logic [5:0] a,
		input logic [71:0] ln, input logic [7:0] bw);
		i_qbs_ctrl_model.issue(r, w, d, a, ln, bw);
	endtask : iss

	task automatic wr(input logic [5:0] a, input logic [71:0] ln,
		input logic [7:0] bw);
		iss(0, 1, 1, a, ln, bw);
		mem[a] = merge(mem[a], ln, bw);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic oa);
		iss(1, 0, 0, a, '0, '0);
		expLn.push_back(mem[a]);
		expOa.push_back(oa);
	endtask : rd

	task automatic chkRd();
		logic [71:0] ln;
		logic        ok;
		logic        oa;
		i_qbs_ctrl_model.pop(ln, ok, oa);
		chk("burst", ln, expLn.pop_front());
		chk("oeN in burst", ok, 1);
		chk("oeN after", oa, expOa.pop_front());
	endtask : chkRd

	task automatic t_lock(input int lim);
		int n = 0;
		while (lock !== 1'b1 && n < lim) begin
			@(posedge linkClk);
			n++;
		end
		chk("lock", lock, 1);
	endtask : t_lock

	task automatic t_retune();
		int n = 0;
		while (upd !== 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (upd !== 1'b1 && n < 40);
		chk("retune gap", n, 16);
	endtask : t_retune

	task automatic t_echo(input logic single);
		@(posedge linkClk);
		repeat (5) begin
			#17;
			chk("echo pos", echoP, single ? linkClk : outClkPos);
			chk("echo neg", echoN, single ? !linkClk : outClkNeg);
		end
	endtask : t_echo

	// forwarding, back-to-back reads and writes
	task automatic t_flow();
		wr(1, 72'h0123456789abcdef01, 8'h00);
		rd(1, 0);
		wr(2, 72'hfedcba98765432100f, 8'h00);
		rd(2, 0);
		iss(0, 0, 0, 0, '0, '0);
		rd(1, 1);
		iss(0, 0, 0, 0, '0, '0);
		repeat (3) chkRd();
	endtask : t_flow

	task automatic t_lanes();
		logic [7:0] byte_write_select_n [4] = '{8'h00, 8'h9c, 8'h63, 8'hff};
		for (int k = 0; k < 4; k++) begin
			wr(3, {9{8'(8'h3c + k * 37)}}, byte_write_select_n[k]);
			iss(0, 0, 0, 0, '0, '0);
			rd(3, 1);
			iss(0, 0, 0, 0, '0, '0);
			chkRd();
		end
	endtask : t_lanes

	task automatic t_refuse();
		logic [71:0] ln;
		logic        ok;
		logic        oa;
		wr(4, 72'h44aa55bb66cc77dd88, 8'h00);
		iss(0, 0, 0, 0, '0, '0);
		wr(5, 72'h13579bdf02468ace11, 8'h00);
		iss(0, 1, 0, 4, '0, '0);
		rd(5, 1);
		iss(1, 0, 0, 4, '0, '0);
		iss(0, 0, 0, 0, '0, '0);
		rd(4, 1);
		iss(0, 0, 0, 0, '0, '0);
		chkRd();
		i_qbs_ctrl_model.pop(ln, ok, oa);
		chkRd();
	endtask : t_refuse

	// both selects from idle: read, write, read, write
	task automatic t_arbit();
		iss(0, 0, 0, 0, '0, '0);
		iss(1, 1, 0, 4, '0, '0);
		expLn.push_back(mem[4]);
		expOa.push_back(1'b0);
		iss(1, 1, 1, 7, 72'h7777000077770000ff, 8'h00);
		mem[7] = 72'h7777000077770000ff;
		iss(1, 1, 0, 5, '0, '0);
		expLn.push_back(mem[5]);
		expOa.push_back(1'b1);
		iss(1, 1, 1, 9, 72'h9999111199991111ee, 8'h00);
		mem[9] = 72'h9999111199991111ee;
		iss(0, 0, 0, 0, '0, '0);
		rd(7, 0);
		iss(0, 0, 0, 0, '0, '0);
		rd(9, 1);
		iss(0, 0, 0, 0, '0, '0);
		repeat (4) chkRd();
	endtask : t_arbit

	initial begin
		doRst(1, 0);
		chk("early lock", lock, 0);
		t_lock(30);
		t_retune();
		t_echo(0);
		t_flow();
		t_lanes();
		t_refuse();
		t_arbit();
		doRst(0, 1);
		t_echo(1);
		t_lock(8);
		t_flow();
		give_verdict();
	end
endmodule : tb
